// >>> logic/uic_pkg.sv
// Shared constants and carrier types for the UART control block
package uic_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [2:0] OFS_DATA  = 3'h0; // Holding / divisor low
  localparam logic [2:0] OFS_IEN   = 3'h1; // Interrupt enable / div high
  localparam logic [2:0] OFS_IDENT = 3'h2; // Ident (rd), fifo ctl (wr)
  localparam logic [2:0] OFS_LCTL  = 3'h3; // Line control

  // Reset values
  localparam logic [7:0] LCR_RST   = 8'h1d;
  localparam logic [7:0] IIR_RST   = 8'h01;
  localparam logic [7:0] DLL_RST   = 8'h01;
  localparam logic [7:0] DLH_RST   = 8'h00;
  localparam logic [7:0] IER_RST   = 8'h00;
  localparam logic [7:0] EFR_RST   = 8'h00;

  // Key for the enhanced register page
  localparam logic [7:0] LCR_EFR_KEY = 8'hbf;

  // Field positions
  localparam int LCR_DLAB    = 7; // Divisor latch access
  localparam int FCR_EN      = 0; // Fifo enable
  localparam int FCR_RXCLR   = 1; // Receive fifo flush
  localparam int FCR_TXCLR   = 2; // Transmit fifo flush
  localparam int FCR_TXT_LO  = 4; // Transmit trigger field
  localparam int FCR_RXT_LO  = 6; // Receive trigger field
  localparam int EFR_AUTOCTS = 7;
  localparam int EFR_AUTORTS = 6;
  localparam int EFR_SPCHAR  = 5;
  localparam int EFR_ENH     = 4;
  localparam int IER_ENH_LO  = 4; // Gated enable bits 7:4

  // Identification codes for bits 5:1
  localparam logic [4:0] ID_LSR  = 5'h03;
  localparam logic [4:0] ID_RXTO = 5'h06;
  localparam logic [4:0] ID_RXD  = 5'h02;
  localparam logic [4:0] ID_THR  = 5'h01;
  localparam logic [4:0] ID_MDM  = 5'h00;
  localparam logic [4:0] ID_GPIO = 5'h18;
  localparam logic [4:0] ID_XOFF = 5'h08;
  localparam logic [4:0] ID_FLOW = 5'h10;

  // Fifo depth and trigger levels in characters / spaces
  localparam logic [6:0] FIFO_DEPTH = 7'd64;
  localparam logic [6:0] TRIG_ONE   = 7'd1;
  localparam logic [6:0] RXT_0 = 7'd8;
  localparam logic [6:0] RXT_1 = 7'd16;
  localparam logic [6:0] RXT_2 = 7'd56;
  localparam logic [6:0] RXT_3 = 7'd60;
  localparam logic [6:0] TXT_0 = 7'd8;
  localparam logic [6:0] TXT_1 = 7'd16;
  localparam logic [6:0] TXT_2 = 7'd32;
  localparam logic [6:0] TXT_3 = 7'd56;

  ////////////////////////////////////////////////////////////////////////
  // Register port request from the serial host front end
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
    logic [2:0] addr;  // Register offset
    logic [7:0] wdata; // Write data
  } uic_req_t;

  // Interrupt sources, raw at the control block input and gated by enables before the encoder
  typedef struct packed {
    logic lsr;      // Line status error
    logic rx_tmo;   // Receiver timeout
    logic rx_data;  // Receive data at trigger
    logic tx_holding;      // Transmit holding space
    logic modem;    // Modem status
    logic gpio;     // Input pin change
    logic xoff_spc; // Xoff or special character
    logic flow_chg; // Cts/rts went inactive
  } uic_src_t;

  // Received character handed over by the receiver
  typedef struct packed {
    logic       valid; // One-cycle strobe
    logic [7:0] data;  // Character
  } uic_char_t;

  // Flow control characters held elsewhere
  typedef struct packed {
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
  } uic_flowch_t;

endpackage

// >>> logic/uic_irq_prio.sv
// Priority encoder for the interrupt identification code
module uic_irq_prio (
  input  wire uic_pkg::uic_src_t src,     // Enabled pending sources
  output logic [4:0]             code,    // Identification bits 5:1
  output logic                   pending  // Any source pending
);
  import uic_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Fixed priority, line status first, flow change last
  always_comb begin
    pending = 1'b1;
    if (src.lsr) begin
      code = ID_LSR;
    end else if (src.rx_tmo) begin
      code = ID_RXTO;
    end else if (src.rx_data) begin
      code = ID_RXD;
    end else if (src.tx_holding) begin
      code = ID_THR;
    end else if (src.modem) begin
      code = ID_MDM;
    end else if (src.gpio) begin
      code = ID_GPIO;
    end else if (src.xoff_spc) begin
      code = ID_XOFF;
    end else if (src.flow_chg) begin
      code = ID_FLOW;
    end else begin
      // Modem code doubles as idle; bit 0 tells them apart
      code    = ID_MDM;
      pending = 1'b0;
    end
  end

endmodule

// >>> logic/uic_ctrl.sv
// Interrupt ident, fifo control and enhanced feature control of a UART
module uic_ctrl #(
  parameter logic [6:0] RTS_HALT   = 7'd56, // Rx level that drops rts
  parameter logic [6:0] RTS_RESUME = 7'd16  // Rx level that restores rts
) (
  input  wire logic                 mclk,        // Uart clock
  input  wire logic                 reset_n,     // Sync reset, low
  input  wire uic_pkg::uic_req_t    req,         // Register request
  output logic [7:0]                rdata,       // Read data, next cycle
  input  wire logic                 supp_bit2,   // Supplementary bit 2
  input  wire uic_pkg::uic_src_t    src_raw,     // Unmasked sources
  input  wire uic_pkg::uic_char_t   rx_char,     // Received character
  input  wire uic_pkg::uic_flowch_t flow_chars,  // Xon/xoff characters
  input  wire logic [6:0]           rx_level,    // Rx fifo fill
  input  wire logic                 cts_n,       // Cts pin, low active
  input  wire logic                 tx_busy,     // Shifter mid character
  input  wire logic                 rts_force_n, // Manual rts level
  output logic [7:0]                ident,       // Identification value
  output logic                      irq_n,       // Interrupt, low active
  output logic                      fifo_en,     // Fifo mode on
  output logic [6:0]                fifo_depth,  // Usable depth
  output logic [6:0]                rx_trig,     // Rx trigger characters
  output logic [6:0]                tx_trig,     // Tx trigger spaces
  output logic                      tx_clr,      // Tx fifo flush pulse
  output logic                      rx_clr,      // Rx fifo flush pulse
  output logic                      tx_hold,     // Stop new tx chars
  output logic                      rts_n,       // Rts pin, low active
  output logic                      rx_store,    // Push char, pulse
  output logic                      xoff_seen,   // Peer asked to stop
  output logic [1:0]                tx_flow_sel, // Tx flow char select
  output logic                      sleep_en,    // Sleep allowed
  output logic [7:0]                line_ctl,    // Line control value
  output logic [15:0]               divisor      // Baud divisor
);
  import uic_pkg::*;

  // Threshold order must leave hysteresis
  if (RTS_RESUME >= RTS_HALT || RTS_HALT > FIFO_DEPTH) begin : g_chk
    $error("rts thresholds out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger decode functions
  function automatic logic [6:0] rx_trig_of(input logic [1:0] c);
    case (c)
      2'b00:   rx_trig_of = RXT_0;
      2'b01:   rx_trig_of = RXT_1;
      2'b10:   rx_trig_of = RXT_2;
      default: rx_trig_of = RXT_3;
    endcase
  endfunction

  function automatic logic [6:0] tx_trig_of(input logic [1:0] c);
    case (c)
      2'b00:   tx_trig_of = TXT_0;
      2'b01:   tx_trig_of = TXT_1;
      2'b10:   tx_trig_of = TXT_2;
      default: tx_trig_of = TXT_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Whole module state
  typedef struct packed {
    logic [7:0]  line_control;      // Line control
    logic [7:0]  dll;      // Divisor low
    logic [7:0]  divisor_high_byte;      // Divisor high
    logic [7:0]  interrupt_enable_reg;      // Interrupt enable
    logic [7:0]  enhanced_feature;      // Enhanced feature
    logic        fen;      // Fifo enable
    logic [1:0]  rxt;      // Rx trigger code
    logic [1:0]  txt;      // Tx trigger code
    logic        txclr;    // Flush pulses
    logic        rxclr;
    logic [7:0]  interrupt_ident;      // Registered ident value
    logic [7:0]  rdata;    // Read data
    logic        xoff_stk; // Sticky xoff/special event
    logic        flow_stk; // Sticky flow change event
    logic        xoff_on;  // Transmit stopped by peer
    logic        half_on;  // First half of combined xon seen
    logic        half_off; // First half of combined xoff seen
    logic        store;    // Push pulse
    logic        rts_n;    // Rts pin
    logic        hold;     // Tx hold
    logic        cts_n_d;  // Cts last cycle
    logic [6:0]  depth;    // Usable fifo depth
    logic [6:0]  rxtrig;   // Decoded rx trigger
    logic [6:0]  txtrig;   // Decoded tx trigger
    logic        sleep;    // Sleep permitted
  } uic_state_t;

  uic_state_t state_reg;  // Registered state
  uic_state_t state_next; // Next state
  uic_src_t   src_en;     // Sources after enables
  logic [4:0] id_code;    // Encoder code
  logic       id_pend;    // Encoder pending

  ////////////////////////////////////////////////////////////////////////
  // Priority encoder
  uic_irq_prio u_prio (
    .src     (src_en),
    .code    (id_code),
    .pending (id_pend)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic       efr_map;   // Enhanced page visible
    logic       dlab;      // Divisor latch page
    logic       enh;       // Enhanced bits writable
    logic [1:0] rxs;       // Rx compare select
    logic [1:0] txs;       // Tx send select
    logic       combined;  // Both pairs in sequence
    logic       either;    // Either pair alone
    logic       on_hit;    // Xon recognised
    logic       off_hit;   // Xoff recognised
    logic       spc_hit;   // Special character seen
    logic       cmp_x2;    // Flow compares xoff2
    logic       id_rd;     // Ident read strobe
    logic [7:0] d;         // Write data
    efr_map  = 1'b0;
    dlab     = 1'b0;
    enh      = 1'b0;
    rxs      = 2'b00;
    txs      = 2'b00;
    combined = 1'b0;
    either   = 1'b0;
    on_hit   = 1'b0;
    off_hit  = 1'b0;
    spc_hit  = 1'b0;
    cmp_x2   = 1'b0;
    id_rd    = 1'b0;
    d        = req.wdata;
    state_next = state_reg;

    efr_map = (state_reg.line_control == LCR_EFR_KEY) && !supp_bit2;
    dlab    = state_reg.line_control[LCR_DLAB];
    enh     = state_reg.enhanced_feature[EFR_ENH];
    rxs     = state_reg.enhanced_feature[1:0];
    txs     = state_reg.enhanced_feature[3:2];

    // Flush strobes last one cycle
    state_next.txclr = 1'b0;
    state_next.rxclr = 1'b0;
    state_next.store = 1'b0;

    // Register writes
    if (req.wr) begin
      case (req.addr)
        OFS_DATA: begin
          if (dlab) begin
            state_next.dll = d;
          end
        end
        OFS_IEN: begin
          if (dlab) begin
            state_next.divisor_high_byte = d;
          end else begin
            state_next.interrupt_enable_reg[3:0] = d[3:0];
            if (enh) begin
              state_next.interrupt_enable_reg[7:IER_ENH_LO] = d[7:IER_ENH_LO];
            end
          end
        end
        OFS_IDENT: begin
          if (efr_map) begin
            state_next.enhanced_feature = d;
          end else begin
            state_next.fen = d[FCR_EN];
            // other bits ignored while fifo off
            if (d[FCR_EN]) begin
              state_next.rxt = d[FCR_RXT_LO +: 2];
              if (enh) begin
                state_next.txt = d[FCR_TXT_LO +: 2];
              end
              state_next.txclr = d[FCR_TXCLR];
              state_next.rxclr = d[FCR_RXCLR];
            end
          end
        end
        OFS_LCTL: state_next.line_control = d;
        default: ;  // Other offsets live elsewhere
      endcase
    end

    // Register reads, answered from flops next cycle
    state_next.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        OFS_DATA:  state_next.rdata = dlab ? state_reg.dll : 8'h00;
        OFS_IEN:   state_next.rdata = dlab ? state_reg.divisor_high_byte : state_reg.interrupt_enable_reg;
        OFS_IDENT: begin
          if (efr_map) begin
            state_next.rdata = state_reg.enhanced_feature;
          end else if (!dlab) begin
            state_next.rdata = state_reg.interrupt_ident;
            id_rd = 1'b1;
          end
        end
        OFS_LCTL:  state_next.rdata = state_reg.line_control;
        default:   state_next.rdata = 8'h00;
      endcase
    end

    // 1011 and 0111 take either pair
    // 0011 and 1111 need both pairs
    combined = (rxs == 2'b11) && (txs == 2'b11 || txs == 2'b00);
    either   = (rxs == 2'b11) && !combined;
    cmp_x2   = rxs[0];
    if (rx_char.valid) begin
      if (combined) begin
        on_hit  = state_reg.half_on  && rx_char.data == flow_chars.xon2;
        off_hit = state_reg.half_off && rx_char.data == flow_chars.xoff2;
        state_next.half_on  = rx_char.data == flow_chars.xon1;
        state_next.half_off = rx_char.data == flow_chars.xoff1;
      end else begin
        state_next.half_on  = 1'b0;
        state_next.half_off = 1'b0;
        on_hit  = ((rxs[1] || either) && rx_char.data == flow_chars.xon1)
               || ((rxs[0] || either) && rx_char.data == flow_chars.xon2);
        off_hit = ((rxs[1] || either) && rx_char.data == flow_chars.xoff1)
               || ((rxs[0] || either) && rx_char.data == flow_chars.xoff2);
      end
      spc_hit = state_reg.enhanced_feature[EFR_SPCHAR]
             && rx_char.data == flow_chars.xoff2;
      // compared xoff2 stays out of fifo
      state_next.store = !(on_hit || off_hit)
                      && !(spc_hit && cmp_x2);
    end

    // Peer flow state; xoff wins over xon
    if (off_hit) begin
      state_next.xoff_on = 1'b1;
    end else if (on_hit || rxs == 2'b00) begin
      state_next.xoff_on = 1'b0;
    end

    // Sticky events: a new event beats the clearing read
    // xoff and special share one flag
    state_next.xoff_stk = (state_reg.xoff_stk && !id_rd)
                       || off_hit || spc_hit;
    state_next.cts_n_d = cts_n;

    if (state_reg.enhanced_feature[EFR_AUTORTS]) begin
      if (rx_level >= RTS_HALT) begin
        state_next.rts_n = 1'b1;
      end else if (rx_level < RTS_RESUME) begin
        state_next.rts_n = 1'b0;
      end
    end else begin
      state_next.rts_n = rts_force_n;
    end

    // cts or rts going inactive
    // Needs the final rts level above, or an rts rise goes unseen
    state_next.flow_stk = (state_reg.flow_stk && !id_rd)
                       || (cts_n && !state_reg.cts_n_d)
                       || (state_next.rts_n && !state_reg.rts_n);

    state_next.hold = (state_reg.enhanced_feature[EFR_AUTOCTS] && cts_n && !tx_busy)
                   || (state_reg.hold && state_reg.enhanced_feature[EFR_AUTOCTS]
                       && cts_n);

    // ident value with mirrors and pending bit
    state_next.interrupt_ident = {state_reg.fen, state_reg.fen, id_code, !id_pend};

    // Decodes registered so every output pin comes from a flop
    // full depth when fifo on
    state_next.depth  = state_next.fen ? FIFO_DEPTH : TRIG_ONE;
    state_next.rxtrig = state_next.fen ? rx_trig_of(state_next.rxt)
                                       : TRIG_ONE;
    state_next.txtrig = state_next.fen ? tx_trig_of(state_next.txt)
                                       : TRIG_ONE;
    state_next.sleep  = state_next.interrupt_enable_reg[4] && state_next.enhanced_feature[EFR_ENH];

    if (!reset_n) begin
      state_next          = '0;
      state_next.line_control      = LCR_RST;
      state_next.dll      = DLL_RST;
      state_next.divisor_high_byte      = DLH_RST;
      state_next.interrupt_enable_reg      = IER_RST;
      state_next.enhanced_feature      = EFR_RST;
      state_next.interrupt_ident      = IIR_RST;
      state_next.cts_n_d  = 1'b1;
      state_next.rts_n    = 1'b1;
      state_next.depth    = TRIG_ONE;
      state_next.rxtrig   = TRIG_ONE;
      state_next.txtrig   = TRIG_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable gating of sources; enhanced ones need the enhanced bit
  always_comb begin
    src_en          = src_raw;
    src_en.lsr      = src_raw.lsr     && state_reg.interrupt_enable_reg[2];
    src_en.rx_tmo   = src_raw.rx_tmo  && state_reg.interrupt_enable_reg[0];
    src_en.rx_data  = src_raw.rx_data && state_reg.interrupt_enable_reg[0];
    src_en.tx_holding      = src_raw.tx_holding     && state_reg.interrupt_enable_reg[1];
    src_en.modem    = src_raw.modem   && state_reg.interrupt_enable_reg[3];
    // ident bits 5:4 need enhanced bit
    src_en.gpio     = src_raw.gpio && state_reg.enhanced_feature[EFR_ENH];
    src_en.xoff_spc = (src_raw.xoff_spc || state_reg.xoff_stk)
                   && state_reg.interrupt_enable_reg[5] && state_reg.enhanced_feature[EFR_ENH];
    src_en.flow_chg = (src_raw.flow_chg || state_reg.flow_stk)
                   && (state_reg.interrupt_enable_reg[7] || state_reg.interrupt_enable_reg[6])
                   && state_reg.enhanced_feature[EFR_ENH];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk) begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  assign rdata       = state_reg.rdata;
  assign ident       = state_reg.interrupt_ident;
  assign irq_n       = state_reg.interrupt_ident[0];
  assign fifo_en     = state_reg.fen;
  assign fifo_depth  = state_reg.depth;
  assign rx_trig     = state_reg.rxtrig;
  assign tx_trig     = state_reg.txtrig;
  assign tx_clr      = state_reg.txclr;
  assign rx_clr      = state_reg.rxclr;
  assign tx_hold     = state_reg.hold;
  assign rts_n       = state_reg.rts_n;
  assign rx_store    = state_reg.store;
  assign xoff_seen   = state_reg.xoff_on;
  assign tx_flow_sel = state_reg.enhanced_feature[3:2];
  assign sleep_en    = state_reg.sleep;
  assign line_ctl    = state_reg.line_control;
  assign divisor     = {state_reg.divisor_high_byte, state_reg.dll};

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_flush_tx_pulse: assert property (
    req.wr && req.addr == OFS_IDENT && req.wdata[FCR_EN]
    && req.wdata[FCR_TXCLR]
    && !(state_reg.line_control == LCR_EFR_KEY && !supp_bit2)
    |=> tx_clr ##1 !tx_clr) else $error("tx flush pulse wrong");
  a_flush_rx_pulse: assert property (
    rx_clr |=> !rx_clr) else $error("rx flush not self clearing");
  a_fifo_off_trig: assert property (
    !fifo_en |-> rx_trig == TRIG_ONE && tx_trig == TRIG_ONE
    && !tx_clr && !rx_clr) else $error("fifo off trigger wrong");
  a_txt_locked: assert property (
    !state_reg.enhanced_feature[EFR_ENH] |=> $stable(state_reg.txt))
    else $error("tx trigger changed without enhanced bit");
  a_ident_pend: assert property (
    ident[0] == 1'b0 |-> ident[7] == ident[6] && ident[5:1] != 5'h1f)
    else $error("ident bits inconsistent");
  a_lsr_first: assert property (
    src_en.lsr |=> ident[5:1] == ID_LSR && !irq_n)
    else $error("line status not top priority");
  a_rts_halt: assert property (
    state_reg.enhanced_feature[EFR_AUTORTS] && rx_level >= RTS_HALT
    |=> rts_n) else $error("rts not dropped at halt");
  a_cts_hold: assert property (
    state_reg.enhanced_feature[EFR_AUTOCTS] && cts_n && !tx_busy |=> tx_hold)
    else $error("tx not held on cts inactive");
  a_ier_gate: assert property (
    !state_reg.enhanced_feature[EFR_ENH] |=> $stable(state_reg.interrupt_enable_reg[7:4]))
    else $error("enhanced enables changed while gated");

endmodule

// >>> tb/uic_host.sv
// Host model issuing register reads and writes
module uic_host (
  input  wire logic       mclk,  // Uart clock
  output uic_pkg::uic_req_t req,   // Register request
  input  wire logic [7:0] rdata  // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  import uic_pkg::*;
  logic [7:0] last_rd; // Read data taken at the latest access, read or write

  initial req = '0;

  ////////////////////////////////////////////////////////////////////////
  // One access; request held across its sampling edge, read taken after
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    @(negedge mclk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk);
    // Answer stands one cycle only, so take it now
    last_rd = rdata;
    req = '0;
  endtask
endmodule

// >>> tb/uic_ctrl_bench.sv
// Self-checking bench for the UART control block
module uic_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uic_pkg::*;
  logic        mclk = 0, reset_n = 0, supp_bit2, cts_n, tx_busy;
  logic        irq_n, fifo_en, tx_clr, rx_clr, tx_hold, rts_n;
  logic        rx_store, xoff_seen, sleep_en;
  logic [7:0]  rdata, ident, line_ctl, s;
  logic [6:0]  rx_level, fifo_depth, rx_trig, tx_trig;
  logic [1:0]  tx_flow_sel;
  logic [15:0] divisor;
  logic [5:0]  e;
  uic_req_t    req;
  uic_src_t    src_raw;
  uic_char_t   rx_char;
  int          err_count = 0, checks = 0, n, k;
  // Trigger tables and codes highest priority first
  localparam logic [6:0] RT [4] = '{7'd8, 7'd16, 7'd56, 7'd60};
  localparam logic [6:0] TT [4] = '{7'd8, 7'd16, 7'd32, 7'd56};
  localparam logic [4:0] CD [8] = '{ID_LSR, ID_RXTO, ID_RXD, ID_THR,
    ID_MDM, ID_GPIO, ID_XOFF, ID_FLOW};

  // Free-running clock, 40 ns period
  always #20 mclk = ~mclk;

  uic_host host_u (.mclk(mclk), .req(req), .rdata(rdata));
  uic_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .req(req),
    .rdata(rdata), .supp_bit2(supp_bit2), .src_raw(src_raw),
    .rx_char(rx_char), .flow_chars({8'h11, 8'h12, 8'h13, 8'h14}),
    .rx_level(rx_level), .cts_n(cts_n), .tx_busy(tx_busy),
    .rts_force_n(1'b0), .ident(ident), .irq_n(irq_n),
    .fifo_en(fifo_en), .fifo_depth(fifo_depth), .rx_trig(rx_trig),
    .tx_trig(tx_trig), .tx_clr(tx_clr), .rx_clr(rx_clr),
    .tx_hold(tx_hold), .rts_n(rts_n), .rx_store(rx_store),
    .xoff_seen(xoff_seen), .tx_flow_sel(tx_flow_sel),
    .sleep_en(sleep_en), .line_ctl(line_ctl), .divisor(divisor));

  ////////////////////////////////////////////////////////////////////////
  // Priority model: first pending source wins, none reads 01
  function automatic logic [5:0] prio(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      if (v[i]) return {CD[7-i], 1'b0};
    return 6'h01;
  endfunction

  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t mismatch %h vs %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host_u.acc(1'b1, a, d);
  endtask
  // Enhanced page write under the key, then back to a plain format
  task automatic enhanced_feature(input logic [7:0] v);
    wr(3'h3, 8'hbf);
    wr(3'h2, v);
    wr(3'h3, 8'h03);
  endtask
  // Offer one character, count store pulses that follow
  task automatic rxc(input logic [7:0] d, output int c);
    c = 0;
    rx_char = '{valid: 1'b1, data: d};
    cyc(1);
    rx_char = '0;
    repeat (3) begin
      c += rx_store;
      cyc(1);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles of the tests
  initial begin
    #(40 * 20000);
    err_count++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(44193));
    {supp_bit2, cts_n, tx_busy, rx_level, src_raw, rx_char} = '0;
    cyc(20);
    reset_n = 1;
    host_u.acc(1'b0, 3'h3, 8'h00);
    chk(host_u.last_rd, 8'h1d);
    chk({ident, irq_n, fifo_en, divisor}, {8'h01, 2'b10, 16'h0001});
    wr(3'h2, 8'hf0);
    chk({fifo_en, rx_trig, tx_trig}, {1'b0, 7'd1, 7'd1});
    enhanced_feature(8'h10);
    wr(3'h1, 8'hef);
    for (int i = 0; i < 16; i++) begin
      wr(3'h2, {i[3:0], 4'h1});
      chk({rx_trig, tx_trig}, {RT[i/4], TT[i%4]});
      cyc(1);
      chk({fifo_depth, ident[7:6]}, {FIFO_DEPTH, 2'b11});
    end
    wr(3'h2, 8'h07);
    n = 0;
    k = 0;
    repeat (3) begin
      n += tx_clr;
      k += rx_clr;
      cyc(1);
    end
    chk({n[3:0], k[3:0]}, 8'h11);
    repeat (40) begin
      k = $urandom % 9;
      s = (k < 8) ? (8'h80 >> k) | ($urandom & (8'h7f >> k)) : 8'h00;
      src_raw = s;
      e = prio(s);
      cyc(2);
      chk({irq_n, ident[5:0]}, {e[0], e});
    end
    src_raw = '0;
    enhanced_feature(8'h00);
    wr(3'h2, 8'hf1);
    chk({rx_trig, tx_trig}, {7'd60, 7'd8});
    wr(3'h3, 8'hbf);
    supp_bit2 = 1;
    wr(3'h2, 8'h90);
    supp_bit2 = 0;
    wr(3'h3, 8'h03);
    cts_n = 1;
    cyc(3);
    chk(tx_hold, 1'b0);
    tx_busy = 1;
    enhanced_feature(8'h90);
    cyc(3);
    chk(tx_hold, 1'b0);
    tx_busy = 0;
    cyc(2);
    chk(tx_hold, 1'b1);
    cts_n = 0;
    cyc(2);
    chk(tx_hold, 1'b0);
    enhanced_feature(8'h50);
    foreach (RT[i]) begin
      rx_level = (i == 0) ? 7'd56 : (i == 1) ? 7'd20 : 7'd10;
      cyc(2);
      chk(rts_n, i < 2);
    end
    host_u.acc(1'b0, 3'h2, 8'h00);
    chk(host_u.last_rd, 8'h20);
    enhanced_feature(8'h30);
    rxc(8'h14, n);
    chk({n[1:0], ident[5:1]}, {2'd1, ID_XOFF});
    enhanced_feature(8'h31);
    rxc(8'h14, n);
    chk({n[1:0], xoff_seen}, 3'b001);
    rxc(8'h12, n);
    chk(xoff_seen, 1'b0);
    enhanced_feature(8'h3b);
    rxc(8'h13, n);
    chk({xoff_seen, tx_flow_sel}, 3'b110);
    enhanced_feature(8'h33);
    rxc(8'h11, n);
    chk(xoff_seen, 1'b1);
    rxc(8'h12, n);
    chk(xoff_seen, 1'b0);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    chk({line_ctl, divisor}, {8'h83, 16'h3412});
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h10);
    chk(sleep_en, 1'b1);
    give_verdict();
  end
endmodule
